// file: src/cnt_fault_defs.vh
/*
  constants of the counter fault reporting block: register offsets, field
  positions, reset values, fault codes and timing counts.
  assumes it is included by bare name from the design files.
*/
`ifndef CNT_FAULT_DEFS_VH
`define CNT_FAULT_DEFS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFS_CTRL 12'h000
`define OFS_STATUS 12'h004
`define OFS_CODES 12'h008
`define OFS_SET_ADDR 12'h00c
`define OFS_SET_DATA 12'h010

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define CTRL_RESTART 0
`define CTRL_RD_NEXT 1
`define CTRL_CODE_EN_LO 2
`define CTRL_LINEAR_LO 4
`define CTRL_BUS_HOLD 6
`define CTRL_PREDEF_LO 8
`define CTRL_RESET_VAL 10'h000

// ----------------------------------------------------------------
// setting memory layout
// ----------------------------------------------------------------
`define SET_DEPTH 24
`define SET_BCD_WORD 5'h00
`define SET_MODE_WORD 5'h01
`define SET_MODE_MAX 16'h0001
`define SET_CNT_BASE 5'h08

// ----------------------------------------------------------------
// main fault codes and the bus fault detail word
// ----------------------------------------------------------------
`define FC_OUT_OF_RANGE 16'h0300
`define FC_BAD_BCD 16'h0310
`define FC_BAD_INIT 16'h0311
`define FC_BAD_LIMITS 16'h0320
`define FC_BAD_CMP 16'h0330
`define FC_DUP_CMP 16'h0331
`define FC_OVERFLOW 16'h0450
`define FC_UNDERFLOW 16'h0460
`define FC_PRESET 16'h0470
`define FC_CPU_MON 16'h0002
`define FC_BUS_CHECK 16'h000e
`define FC_BUS_DETAIL 16'h0000

// ----------------------------------------------------------------
// fault list and timing
// ----------------------------------------------------------------
`define LIST_DEPTH 30
`define CLK_PERIOD_NS 5
`define MS_IN_NS 1000000
`define CYC_PER_MS (`MS_IN_NS / `CLK_PERIOD_NS)
`define MON_TIME_MS 16'd100

`endif

// file: src/cnt_fault_unit.v
/*
  fault detection and reporting of a two-channel counter unit: setting
  checks at start-up, runtime counter faults, host faults, fault list,
  lamps and the output state on a bus fault. registers over APB.
  assumes counter events, reset, preset and host signals are synchronous
  one-cycle pulses from the counting logic next to this block.
*/
`timescale 1ns/10ps
`include "cnt_fault_defs.vh"

// Behaviour
// R1 - setting checks only at start or restart
// R2 - setting fault: store fault, stop counting
// R3 - word outside range: 0300, bcd offset
// R4 - digit above nine: 0310, bcd offset
// R5 - initial value off range: 0311
// R6 - upper below lower limit: 0320
// R7 - detail: counter top nibble, data low
// R8 - range limit off range: 0330
// R9 - compare value off range: 0330
// R10 - equal compare values: 0331
// R11 - host fixes settings, then restarts
// R12 - overflow faults only linear, code enabled
// R13 - overflow reports 0450 with counter
// R14 - underflow reports 0460 with counter
// R15 - reset or preset clears over/underflow
// R16 - preset off range reports 0470
// R17 - reset or valid preset clears it
// R18 - host lamp on cpu or bus fault
// R19 - cpu silence reports 0002, time ms
// R20 - bus check fault stores 000e, 0000
// R21 - bus fault: outputs hold or predefined
// R22 - global flag while any fault stands
// R23 - thirty faults kept, read-next steps
// R24 - simultaneous faults stored in fixed order
module cnt_fault_unit #(
  parameter CYC_PER_MS = `CYC_PER_MS,
  parameter [15:0] MON_MS = `MON_TIME_MS
) (
  input wire CLK,
  input wire SYS_RST,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [11:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output reg PREADY,
  output reg PSLVERR,
  input wire [1:0] OVERFLOW_IN,
  input wire [1:0] UNDERFLOW_IN,
  input wire [1:0] COUNTER_RESET_IN,
  input wire [1:0] PRESET_IN,
  input wire [1:0] PRESET_VALID_IN,
  input wire CPU_ALIVE_IN,
  input wire BUS_CHECK_FAULT_IN,
  input wire [1:0] COUNTER_OUT_IN,
  output reg [1:0] COUNTER_OUT,
  output reg HALT_COUNTING,
  output reg GLOBAL_FAULT_FLAG,
  output reg UNIT_FAULT_LAMP,
  output reg HOST_FAULT_LAMP
);

  // ----------------------------------------------------------------
  // states and storage
  // ----------------------------------------------------------------
  localparam [2:0] ST_SCAN = 3'b001; // walking the setting memory
  localparam [2:0] ST_RUN = 3'b010; // normal counting
  localparam [2:0] ST_HALT = 3'b100; // stopped on a setting fault

  reg [2:0] state_reg; // start-up sequencer
  reg [4:0] idx_reg; // word under check
  reg [15:0] set_reg [0:`SET_DEPTH-1]; // setting_memory_area
  reg [9:0] ctrl_reg; // control bits
  reg [4:0] set_addr_reg; // setting memory pointer
  reg restart_reg; // restart request, one cycle
  reg rd_next_q_reg; // last read_next_fault_request
  reg cfg_fault_reg; // setting fault seen in this start
  reg [1:0] ovf_reg; // overflow standing per counter
  reg [1:0] udf_reg; // underflow standing per counter
  reg [1:0] pre_reg; // preset fault standing per counter
  reg cpu_reg; // cpu monitoring fault
  reg bus_reg; // bus check fault
  reg [7:0] pend_reg; // runtime faults waiting for the list
  reg [15:0] main_fault_code; // shown main code
  reg [15:0] fault_detail_word; // shown detail
  reg [17:0] tick_reg; // divider to one millisecond
  reg [15:0] ms_reg; // milliseconds without cpu answer

  wire [1:0] code_en = ctrl_reg[`CTRL_CODE_EN_LO +: 2];
  wire [1:0] linear = ctrl_reg[`CTRL_LINEAR_LO +: 2];
  wire read_next_fault_request = ctrl_reg[`CTRL_RD_NEXT];
  wire rd_edge = read_next_fault_request & ~rd_next_q_reg; // R23
  wire run = (state_reg == ST_RUN);

  // ----------------------------------------------------------------
  // setting check of the word under idx
  // ----------------------------------------------------------------
  wire [4:0] base = idx_reg & 5'h18; // first word of this counter
  wire [2:0] sub = idx_reg[2:0]; // word within counter group
  wire [15:0] word = set_reg[idx_reg];
  wire [15:0] lo = set_reg[base];
  wire [15:0] hi = set_reg[base | 5'h01];
  wire [3:0] cnum = idx_reg[4] ? 4'h2 : 4'h1;
  wire outside = (word < lo) || (word > hi);
  wire [15:0] bcd_ofs = {8'h00, (idx_reg >= 5'd20) ? 4'h2 :
    (idx_reg >= 5'd10) ? 4'h1 : 4'h0,
    (idx_reg >= 5'd20) ? idx_reg[3:0] - 4'h4 :
    (idx_reg >= 5'd10) ? idx_reg[3:0] - 4'ha : idx_reg[3:0]};
  wire [15:0] cnt_detail = {cnum, 9'h000, sub - 3'h2}; // R7

  reg dup; // earlier compare value equal to this one
  reg bad_digit; // some nibble above nine
  reg cfg_hit; // this word is faulty
  reg [31:0] cfg_code; // {detail, main} for the faulty word
  integer j;

  // combinational checks; one finding per word keeps the order fixed
  always @* begin
    dup = 1'b0;
    bad_digit = 1'b0;
    cfg_hit = 1'b0;
    cfg_code = 32'h0000_0000;
    for (j = 3; j < 6; j = j + 1) begin
      if (j[2:0] < sub && set_reg[base | j[4:0]] == word) begin
        dup = 1'b1;
      end
    end
    for (j = 0; j < 4; j = j + 1) begin
      if (word[j*4 +: 4] > 4'h9) begin
        bad_digit = 1'b1;
      end
    end
    if (idx_reg == `SET_BCD_WORD) begin
      if (bad_digit) begin
        cfg_hit = 1'b1; // R4
        cfg_code = {bcd_ofs, `FC_BAD_BCD};
      end
    end else if (idx_reg == `SET_MODE_WORD) begin
      if (word > `SET_MODE_MAX) begin
        cfg_hit = 1'b1; // R3
        cfg_code = {bcd_ofs, `FC_OUT_OF_RANGE};
      end
    end else if (idx_reg >= `SET_CNT_BASE) begin
      if (sub == 3'h1 && hi < lo) begin
        cfg_hit = 1'b1; // R6
        cfg_code = {cnum, 12'h001, `FC_BAD_LIMITS};
      end else if (sub == 3'h2 && outside) begin
        cfg_hit = 1'b1; // R5
        cfg_code = {bcd_ofs, `FC_BAD_INIT};
      end else if (sub >= 3'h3 && sub <= 3'h6) begin
        // the same words are range limits in range mode, values otherwise
        if (outside) begin
          cfg_hit = 1'b1; // R8 R9
          cfg_code = {cnt_detail, `FC_BAD_CMP};
        end else if (dup) begin
          cfg_hit = 1'b1; // R10
          cfg_code = {cnt_detail, `FC_DUP_CMP};
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // start-up sequencer
  // ----------------------------------------------------------------
  // a restart re-runs the scan, which is how corrected settings take hold
  always @(posedge CLK) begin
    if (SYS_RST || restart_reg) begin
      state_reg <= ST_SCAN; // R1 R11
      idx_reg <= 5'h00;
      cfg_fault_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_SCAN: begin
          if (cfg_hit) begin
            cfg_fault_reg <= 1'b1; // R2
          end
          if (idx_reg == `SET_DEPTH - 1) begin
            state_reg <= (cfg_fault_reg || cfg_hit) ? ST_HALT : ST_RUN; // R2
          end else begin
            idx_reg <= idx_reg + 5'h01;
          end
        end
        ST_RUN: begin
          state_reg <= ST_RUN;
        end
        ST_HALT: begin
          state_reg <= ST_HALT; // only a restart or a system reset leaves
        end
        default: begin
          state_reg <= ST_SCAN;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // runtime fault causes
  // ----------------------------------------------------------------
  wire [1:0] ovf_set = OVERFLOW_IN & linear & code_en & {2{run}}; // R12
  wire [1:0] udf_set = UNDERFLOW_IN & linear & code_en & {2{run}}; // R12
  wire [1:0] pre_set = PRESET_IN & ~PRESET_VALID_IN & {2{run}};
  wire [1:0] cnt_clr = COUNTER_RESET_IN | PRESET_IN;
  wire [1:0] pre_clr = COUNTER_RESET_IN | (PRESET_IN & PRESET_VALID_IN);
  wire cpu_set = run && (ms_reg >= MON_MS) && !cpu_reg;
  wire bus_set = BUS_CHECK_FAULT_IN && !bus_reg;
  wire [7:0] ev = {pre_set, udf_set, ovf_set, cpu_set, bus_set};

  // set wins over clear when both land in the same cycle
  always @(posedge CLK) begin
    if (SYS_RST || restart_reg) begin
      ovf_reg <= 2'b00;
      udf_reg <= 2'b00;
      pre_reg <= 2'b00;
    end else begin
      ovf_reg <= ovf_set | (ovf_reg & ~cnt_clr); // R13 R15
      udf_reg <= udf_set | (udf_reg & ~cnt_clr); // R14 R15
      pre_reg <= pre_set | (pre_reg & ~pre_clr); // R16 R17
    end
  end

  // host faults stand until the controller resets the unit
  always @(posedge CLK) begin
    if (SYS_RST) begin
      cpu_reg <= 1'b0;
      bus_reg <= 1'b0;
    end else begin
      cpu_reg <= cpu_reg | cpu_set; // R19
      bus_reg <= bus_reg | bus_set; // R20
    end
  end

  // ----------------------------------------------------------------
  // cpu monitoring timer
  // ----------------------------------------------------------------
  // the millisecond count saturates so a long silence reports once
  always @(posedge CLK) begin
    if (SYS_RST || !run || CPU_ALIVE_IN) begin
      tick_reg <= 18'h00000;
      ms_reg <= 16'h0000;
    end else if (tick_reg == CYC_PER_MS - 1) begin
      tick_reg <= 18'h00000;
      if (ms_reg != 16'hffff) begin
        ms_reg <= ms_reg + 16'h0001; // R19
      end
    end else begin
      tick_reg <= tick_reg + 18'h00001;
    end
  end

  // ----------------------------------------------------------------
  // pick one fault per cycle for the list
  // ----------------------------------------------------------------
  reg [7:0] pick; // one-hot choice among waiting faults
  reg [31:0] rt_code; // {detail, main} of the chosen fault
  wire [7:0] waiting = pend_reg | ev;
  integer k;

  // lowest bit wins: bus, cpu, overflow, underflow, preset
  always @* begin
    pick = 8'h00;
    rt_code = 32'h0000_0000;
    for (k = 7; k >= 0; k = k - 1) begin
      if (waiting[k]) begin
        pick = 8'h00;
        pick[k] = 1'b1; // R24
      end
    end
    case (pick)
      8'h01: rt_code = {`FC_BUS_DETAIL, `FC_BUS_CHECK}; // R20
      8'h02: rt_code = {MON_MS, `FC_CPU_MON}; // R19
      8'h04: rt_code = {16'h0001, `FC_OVERFLOW}; // R13
      8'h08: rt_code = {16'h0002, `FC_OVERFLOW}; // R13
      8'h10: rt_code = {16'h0001, `FC_UNDERFLOW}; // R14
      8'h20: rt_code = {16'h0002, `FC_UNDERFLOW}; // R14
      8'h40: rt_code = {16'h0001, `FC_PRESET}; // R16
      8'h80: rt_code = {16'h0002, `FC_PRESET}; // R16
      default: rt_code = 32'h0000_0000;
    endcase
  end

  wire cfg_push = (state_reg == ST_SCAN) && cfg_hit;
  wire rt_push = !cfg_push && (waiting != 8'h00); // scan findings first
  wire push = cfg_push || rt_push;
  wire [31:0] push_code = cfg_push ? cfg_code : rt_code;

  // faults that lose the pick wait here for a later cycle
  always @(posedge CLK) begin
    if (SYS_RST) begin
      pend_reg <= 8'h00;
    end else begin
      pend_reg <= waiting & ~(rt_push ? pick : 8'h00); // R24
    end
  end

  wire [31:0] peek;
  wire peek_valid;
  wire [4:0] list_count;

  fault_list #(
    .DEPTH(`LIST_DEPTH),
    .W(32),
    .PW(5)
  ) u_list (
    .clk(CLK),
    .rst(SYS_RST),
    .clr(restart_reg),
    .push(push),
    .push_data(push_code),
    .next(rd_edge),
    .peek(peek),
    .peek_valid(peek_valid),
    .count(list_count)
  );

  // ----------------------------------------------------------------
  // shown codes, flag and lamps
  // ----------------------------------------------------------------
  wire unit_any = cfg_fault_reg | (|ovf_reg) | (|udf_reg) | (|pre_reg);
  wire host_any = cpu_reg | bus_reg;
  wire any = unit_any | host_any | (|pend_reg);

  // a new fault shows at once; read-next steps; all clear shows zero
  always @(posedge CLK) begin
    if (SYS_RST || restart_reg) begin
      main_fault_code <= 16'h0000;
      fault_detail_word <= 16'h0000;
    end else if (push) begin
      main_fault_code <= push_code[15:0];
      fault_detail_word <= push_code[31:16];
    end else if (rd_edge) begin
      main_fault_code <= peek[15:0]; // R23
      fault_detail_word <= peek[31:16];
    end else if (GLOBAL_FAULT_FLAG && !any) begin
      main_fault_code <= 16'h0000; // R22
      fault_detail_word <= 16'h0000;
    end
  end

  // all indicator outputs come from flops
  always @(posedge CLK) begin
    if (SYS_RST) begin
      GLOBAL_FAULT_FLAG <= 1'b0;
      UNIT_FAULT_LAMP <= 1'b0;
      HOST_FAULT_LAMP <= 1'b0;
      HALT_COUNTING <= 1'b1;
    end else begin
      GLOBAL_FAULT_FLAG <= any | push; // R22
      UNIT_FAULT_LAMP <= unit_any;
      HOST_FAULT_LAMP <= host_any | bus_set | cpu_set; // R18
      HALT_COUNTING <= !run; // R2
    end
  end

  // ----------------------------------------------------------------
  // counter outputs on a bus fault
  // ----------------------------------------------------------------
  // hold keeps the last value, since the bus state can no longer be trusted
  always @(posedge CLK) begin
    if (SYS_RST) begin
      COUNTER_OUT <= 2'b00;
    end else if (bus_reg || bus_set) begin
      if (!ctrl_reg[`CTRL_BUS_HOLD]) begin
        COUNTER_OUT <= ctrl_reg[`CTRL_PREDEF_LO +: 2]; // R21
      end
    end else begin
      COUNTER_OUT <= COUNTER_OUT_IN;
    end
  end

  // ----------------------------------------------------------------
  // APB slave, no wait state
  // ----------------------------------------------------------------
  wire setup = PSEL && !PENABLE;
  wire wr = PSEL && PENABLE && PREADY && PWRITE; // write takes effect here
  reg [31:0] rd_mux; // read value of the addressed register
  reg mapped; // address hits a register

  always @* begin
    rd_mux = 32'h0000_0000;
    mapped = 1'b1;
    case (PADDR)
      `OFS_CTRL: rd_mux = {22'h000000, ctrl_reg};
      `OFS_STATUS: rd_mux = {20'h00000, list_count, 2'b00, state_reg[0],
        HALT_COUNTING, host_any, unit_any, GLOBAL_FAULT_FLAG};
      `OFS_CODES: rd_mux = {fault_detail_word, main_fault_code};
      `OFS_SET_ADDR: rd_mux = {27'h0000000, set_addr_reg};
      `OFS_SET_DATA: rd_mux = {16'h0000, set_reg[set_addr_reg]};
      default: mapped = 1'b0;
    endcase
  end

  // answer is prepared in setup and stands through the access cycle
  always @(posedge CLK) begin
    if (SYS_RST) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h0000_0000;
    end else begin
      PREADY <= setup;
      PSLVERR <= setup && !mapped;
      PRDATA <= (setup && !PWRITE) ? rd_mux : 32'h0000_0000;
    end
  end

  // register writes; the restart bit only makes a one-cycle pulse
  always @(posedge CLK) begin
    if (SYS_RST) begin
      ctrl_reg <= `CTRL_RESET_VAL;
      set_addr_reg <= 5'h00;
      restart_reg <= 1'b0;
      rd_next_q_reg <= 1'b0;
    end else begin
      rd_next_q_reg <= read_next_fault_request;
      restart_reg <= wr && PADDR == `OFS_CTRL && PWDATA[`CTRL_RESTART];
      if (wr && PADDR == `OFS_CTRL) begin
        ctrl_reg <= {PWDATA[9:1], 1'b0};
      end
      if (wr && PADDR == `OFS_SET_ADDR) begin
        set_addr_reg <= PWDATA[4:0];
      end
    end
  end

  // setting words have no reset; they are checked at the next start
  always @(posedge CLK) begin
    if (wr && PADDR == `OFS_SET_DATA && set_addr_reg < `SET_DEPTH) begin
      set_reg[set_addr_reg] <= PWDATA[15:0];
    end
  end

endmodule

// file: src/fault_list.v
/*
  fault list: keeps faults in order of arrival and a read cursor that
  walks over them, wrapping after the last one.
  assumes one clock, synchronous active high reset and a clear pulse.
*/
`timescale 1ns/10ps
module fault_list #(
  parameter DEPTH = 30,
  parameter W = 32,
  parameter PW = 5
) (
  input wire clk,
  input wire rst,
  input wire clr,
  input wire push,
  input wire [W-1:0] push_data,
  input wire next,
  output wire [W-1:0] peek,
  output wire peek_valid,
  output wire [PW-1:0] count
);

  reg [W-1:0] mem_reg [0:DEPTH-1]; // stored faults, oldest first
  reg [PW-1:0] count_reg; // number of stored faults
  reg [PW-1:0] cur_reg; // read cursor
  wire room = ({{(32-PW){1'b0}}, count_reg} < DEPTH); // list full drops newer faults

  // ----------------------------------------------------------------
  // per entry storage
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi = gi + 1) begin : g_entry
      always @(posedge clk) begin
        if (push && room && {{(32-PW){1'b0}}, count_reg} == gi) begin
          mem_reg[gi] <= push_data; // R23
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // count and cursor
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (rst || clr) begin
      count_reg <= {PW{1'b0}};
      cur_reg <= {PW{1'b0}};
    end else begin
      if (push && room) begin
        count_reg <= count_reg + 1'b1;
      end
      if (next) begin
        // past the last entry the cursor wraps so the list scrolls again
        if (cur_reg < count_reg) begin
          cur_reg <= cur_reg + 1'b1; // R23
        end else begin
          cur_reg <= {PW{1'b0}};
        end
      end
    end
  end

  assign peek_valid = (cur_reg < count_reg);
  assign peek = peek_valid ? mem_reg[cur_reg] : {W{1'b0}};
  assign count = count_reg;

endmodule

// file: verification/cnt_fault_chk.sv
/*
  port-level checker of the counter fault reporting block.
  assumes it is bound to cnt_fault_unit and sees only its ports.
*/
`timescale 1ns/10ps
module cnt_fault_chk (
  input wire CLK,
  input wire SYS_RST,
  input wire PSEL,
  input wire PENABLE,
  input wire PREADY,
  input wire PSLVERR,
  input wire BUS_CHECK_FAULT_IN,
  input wire [1:0] COUNTER_OUT,
  input wire HALT_COUNTING,
  input wire GLOBAL_FAULT_FLAG,
  input wire UNIT_FAULT_LAMP,
  input wire HOST_FAULT_LAMP
);
  // ----------------------------------------------------------------
  // helper logic
  // ----------------------------------------------------------------
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  reg [2:0] bus_age_reg; // cycles since a bus check fault, stays at 7 until the next bus check fault wraps it to 0
  always @(posedge CLK) begin
    if (SYS_RST) begin
      bus_age_reg <= 3'h0;
    end else if (BUS_CHECK_FAULT_IN || (bus_age_reg != 3'h0 && bus_age_reg != 3'h7)) begin
      bus_age_reg <= bus_age_reg + 3'h1;
    end
  end
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  pready_setup_a: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("no ready in the access cycle");
  slverr_ready_a: assert property (PSLVERR |-> PREADY)
    else $error("error answer without ready");
  host_lamp_a: assert property (BUS_CHECK_FAULT_IN |=> HOST_FAULT_LAMP)
    else $error("host lamp late after bus fault");
  host_hold_a: assert property (HOST_FAULT_LAMP |=> HOST_FAULT_LAMP)
    else $error("host lamp dropped without reset");
  host_flag_a: assert property (HOST_FAULT_LAMP |-> GLOBAL_FAULT_FLAG)
    else $error("host fault without global flag");
  unit_flag_a: assert property (UNIT_FAULT_LAMP |-> GLOBAL_FAULT_FLAG)
    else $error("unit fault without global flag");
  halt_rst_a: assert property (disable iff (1'b0) SYS_RST |=> HALT_COUNTING)
    else $error("counting not stopped in reset");
  halt_scan_a: assert property ($fell(SYS_RST) |-> HALT_COUNTING [*8])
    else $error("counting started before the scan");
  bus_out_a: assert property (bus_age_reg == 3'h7 |-> $stable(COUNTER_OUT))
    else $error("outputs moved after bus fault");
endmodule

bind cnt_fault_unit cnt_fault_chk u_cnt_fault_chk (.CLK(CLK), .SYS_RST(SYS_RST),
  .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .BUS_CHECK_FAULT_IN(BUS_CHECK_FAULT_IN), .COUNTER_OUT(COUNTER_OUT),
  .HALT_COUNTING(HALT_COUNTING), .GLOBAL_FAULT_FLAG(GLOBAL_FAULT_FLAG),
  .UNIT_FAULT_LAMP(UNIT_FAULT_LAMP), .HOST_FAULT_LAMP(HOST_FAULT_LAMP));

// file: verification/counter_unit_error_reporting_test.sv
/*
  self-checking bench of the counter fault reporting block.
  assumes the design headers are on the include path.
*/
`timescale 1ns/10ps
`include "cnt_fault_defs.vh"
module counter_unit_error_reporting_test;
  reg clk = 1'b0;
  reg sys_rst = 1'b1;
  reg psel = 1'b0, penable = 1'b0, pwrite = 1'b0, mute = 1'b0, hit = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0, rd;
  reg serr;
  reg [1:0] ovf = 2'h0, udf = 2'h0, crst = 2'h0, pre = 2'h0, pval = 2'h0, cout_in = 2'h0;
  wire [31:0] prdata;
  wire pready, pslverr, alive, busf, halt, gflag, ulamp, hlamp;
  wire [1:0] cout;
  integer err_count = 0, compares = 0, cycles = 0;

  cnt_fault_unit #(.CYC_PER_MS(10), .MON_MS(16'd3)) u_cnt_fault_unit (.CLK(clk),
    .SYS_RST(sys_rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .OVERFLOW_IN(ovf), .UNDERFLOW_IN(udf), .COUNTER_RESET_IN(crst), .PRESET_IN(pre),
    .PRESET_VALID_IN(pval), .CPU_ALIVE_IN(alive), .BUS_CHECK_FAULT_IN(busf),
    .COUNTER_OUT_IN(cout_in), .COUNTER_OUT(cout), .HALT_COUNTING(halt),
    .GLOBAL_FAULT_FLAG(gflag), .UNIT_FAULT_LAMP(ulamp), .HOST_FAULT_LAMP(hlamp));
  cpu_bus_model u_cpu_bus_model (.clk(clk), .rst(sys_rst), .mute(mute), .hit(hit),
    .alive(alive), .bus_fault(busf));

  // ----------------------------------------------------------------
  // clock, timeout and shared tasks
  // ----------------------------------------------------------------
  always #2.5 clk = ~clk;
  // a hung handshake must not stall the run
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count = err_count + 1;
      wrap_up;
    end
  end
  task wrap_up;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    compares = compares + 1;
    if (got !== exp) begin
      err_count = err_count + 1;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer; the request stands until ready is seen high
  task apb(input wr, input [11:0] a, input [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task codes(input [15:0] main, input [15:0] det);
    apb(1'b0, `OFS_CODES, 32'h0);
    chk(rd, {det, main});
  endtask
  // one-cycle counter events; the preset-valid level stays put
  task ev(input [1:0] o, input [1:0] u, input [1:0] r, input [1:0] p, input [1:0] v);
    @(posedge clk);
    {ovf, udf, crst, pre, pval} <= {o, u, r, p, v};
    @(posedge clk);
    {ovf, udf, crst, pre} <= 8'h00;
    repeat (2) @(posedge clk);
  endtask
  function [15:0] good(input [4:0] i);
    if (i < 5'h08) good = (i == 5'h00) ? 16'h0012 : 16'h0000;
    else if (i[2:0] == 3'h0) good = 16'h0010; // low limit
    else if (i[2:0] == 3'h1) good = 16'h0100; // high limit
    else if (i[2:0] == 3'h7) good = 16'h0000;
    else good = 16'h0020 + {13'h0, i[2:0]}; // initial 0x22, compare 0x23..0x26
  endfunction
  task setw(input [4:0] i, input [15:0] v);
    apb(1'b1, `OFS_SET_ADDR, {27'h0, i});
    apb(1'b1, `OFS_SET_DATA, {16'h0, v});
  endtask
  task restart; // codes enabled, counter 1 linear, hold outputs on bus fault
    apb(1'b1, `OFS_CTRL, 32'h5d);
    repeat (30) @(posedge clk);
  endtask
  task cfg_case(input [4:0] i, input [15:0] v, input [15:0] main, input [15:0] det);
    setw(i, v);
    restart;
    chk({31'h0, halt}, 32'h1);
    codes(main, det);
    setw(i, good(i));
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task config_test;
    integer k;
    for (k = 0; k < 24; k = k + 1) setw(k[4:0], good(k[4:0]));
    cfg_case(5'h01, 16'h0002, `FC_OUT_OF_RANGE, 16'h0001);
    cfg_case(5'h00, 16'h001a, `FC_BAD_BCD, 16'h0000);
    cfg_case(5'h12, 16'h0200, `FC_BAD_INIT, 16'h0018);
    cfg_case(5'h0b, 16'h0500, `FC_BAD_CMP, 16'h1001);
    cfg_case(5'h16, 16'h0023, `FC_DUP_CMP, 16'h2004);
    restart;
    chk({31'h0, halt}, 32'h0);
    setw(5'h01, 16'h0002);
    repeat (5) @(posedge clk);
    chk({31'h0, gflag}, 32'h0);
    setw(5'h01, 16'h0000);
    apb(1'b0, 12'h0ff, 32'h0);
    chk({31'h0, serr}, 32'h1);
  endtask
  task runtime_test;
    ev(2'b10, 2'b00, 2'b00, 2'b00, 2'b00);
    chk({31'h0, gflag}, 32'h0);
    ev(2'b01, 2'b00, 2'b00, 2'b00, 2'b00);
    codes(`FC_OVERFLOW, 16'h0001);
    chk({31'h0, gflag}, 32'h1);
    chk({31'h0, ulamp}, 32'h1);
    ev(2'b00, 2'b00, 2'b01, 2'b00, 2'b00);
    chk({31'h0, gflag}, 32'h0);
    ev(2'b00, 2'b01, 2'b00, 2'b00, 2'b00);
    codes(`FC_UNDERFLOW, 16'h0001);
    ev(2'b00, 2'b00, 2'b00, 2'b01, 2'b01);
    chk({31'h0, gflag}, 32'h0);
    ev(2'b00, 2'b00, 2'b00, 2'b10, 2'b00);
    codes(`FC_PRESET, 16'h0002);
    ev(2'b00, 2'b00, 2'b00, 2'b10, 2'b10);
    chk({31'h0, gflag}, 32'h0);
    restart;
    ev(2'b01, 2'b00, 2'b00, 2'b10, 2'b00);
    apb(1'b1, `OFS_CTRL, 32'h5e);
    apb(1'b1, `OFS_CTRL, 32'h5c);
    codes(`FC_OVERFLOW, 16'h0001);
    apb(1'b1, `OFS_CTRL, 32'h5e);
    apb(1'b1, `OFS_CTRL, 32'h5c);
    codes(`FC_PRESET, 16'h0002);
  endtask
  task host_test;
    mute <= 1'b1;
    repeat (60) @(posedge clk);
    codes(`FC_CPU_MON, 16'h0003);
    chk({31'h0, hlamp}, 32'h1);
    mute <= 1'b0;
    sys_rst <= 1'b1;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (30) @(posedge clk);
    apb(1'b1, `OFS_CTRL, 32'h5c);
    cout_in <= 2'b10;
    repeat (3) @(posedge clk);
    hit <= 1'b1;
    repeat (3) @(posedge clk);
    hit <= 1'b0;
    cout_in <= 2'b01;
    repeat (4) @(posedge clk);
    chk({30'h0, cout}, 32'h2);
    codes(`FC_BUS_CHECK, `FC_BUS_DETAIL);
    chk({31'h0, hlamp}, 32'h1);
  endtask

  initial begin
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (30) @(posedge clk);
    config_test;
    runtime_test;
    host_test;
    wrap_up;
  end
endmodule

// file: verification/cpu_bus_model.sv
/*
  model of the controller cpu on the i/o bus: alive pulses, silence and
  bus check faults on command.
  assumes the bench drives mute and hit after clock edges.
*/
`timescale 1ns/10ps
module cpu_bus_model (
  input wire clk,
  input wire rst,
  input wire mute,
  input wire hit,
  output reg alive,
  output reg bus_fault
);
  reg [2:0] tick_reg; // alive every eighth cycle, well inside the watch time
  // a muted cpu simply stops answering, as a hung controller would
  always @(posedge clk) begin
    if (rst) begin
      tick_reg <= 3'h0;
      alive <= 1'b0;
      bus_fault <= 1'b0;
    end else begin
      tick_reg <= tick_reg + 3'h1;
      alive <= !mute && tick_reg == 3'h7;
      bus_fault <= hit;
    end
  end
endmodule
